// ### hw/mcu8_cfg.svh
`ifndef MCU8_CFG_SVH
`define MCU8_CFG_SVH

// register bus offsets (byte addresses)
`define CSR_CTRL     4'h0
`define CSR_STAT     4'h4
`define CSR_CORE     4'h8
`define CSR_PTR      4'hc

// control register fields
`define CTRL_RUN     0
`define CTRL_GIE_CLR 1

// internal system registers in the 0x80..0x87 window
`define SR_BASE      5'h10
`define SR_R         8'h82
`define SR_ZP        8'h83
`define SR_YP        8'h84
`define SR_PAGE      8'h85
`define SR_FLAG      8'h86
`define SR_BANK      8'h87

// flag register bit positions
`define FL_C         0
`define FL_DC        1
`define FL_Z         2

// reset values
`define RST_PC       16'h0000
`define RST_BYTE     8'h00

// extra cycles beyond the first one of an instruction
`define XC_TWO       2'd1
`define XC_NONE      2'd0

`endif

// ### hw/mcu8_pkg.sv
`default_nettype none
package mcu8_pkg;

    // operation codes in instruction bits 13:8 (top bits 00)
    typedef enum logic [5:0] {
        op_nop, op_ld_m, op_st_m, op_bz_ld_m, op_bz_st_m, op_ld_i,
        op_trade, op_bz_trade, op_table_rd,
        op_addc_a, op_addc_m, op_add_a, op_add_m, op_bz_add_m, op_add_i,
        op_subb_a, op_subb_m, op_sub_a, op_sub_m, op_sub_i,
        op_dec_adj, op_product,
        op_and_a, op_and_m, op_and_i, op_or_a, op_or_m, op_or_i,
        op_xor_a, op_xor_m, op_xor_i,
        op_nib_a, op_nib_m, op_rotr_a, op_rotr_m, op_rotl_a, op_rotl_m,
        op_clr_m, op_cmp_i, op_cmp_m, op_inc_a, op_inc_m, op_dec_a,
        op_dec_m, op_ret, op_iret, op_save, op_restore
    } op_t;

    typedef enum logic {st_exec, st_wait} state_t;

endpackage

`default_nettype wire

// ### hw/mcu8_instruction_execute.sv
// Behaviour
// - bank-zero immediate move targets only 0x80..0x87, one cycle, no flags.
// - memory-writing instructions other than plain store and clear add one cycle when operand is data RAM below 0x80.
// - conditional skips add one cycle when the condition holds.
// - additions set carry on eight-bit overflow, clear it otherwise.
// - subtractions clear carry on borrow, set it when no borrow.
// - bank-zero add-to-memory writes sum back, updates carry, 1+N cycles.
// - product puts low byte in accumulator, high in R, two cycles, zero.
// - table read loads R and accumulator from program word at Y:Z, two cycles.
// - decimal adjust converts accumulator to packed decimal in one cycle.
// - compare updates zero and carry, stores nothing, skips when equal.
// - memory increment/decrement write back, skip on zero, 1+N+S cycles.
// - bit tests skip on selected bit zero or one, 1+S cycles.
// - jump loads PC 13:0 from operand, 15:14 from page select, two cycles.
// - call pushes the full 16-bit return address PC+1 then jumps, two cycles.
// - interrupt return restores PC and enables global interrupt, two cycles.
// - save/restore copy accumulator and flags, timeout/power-down bits untouched.
// - bit write alters only the selected bit, 1+N cycles, no flags.
// - nibble exchange swaps halves into accumulator, memory form writes back.
`timescale 1ns/100ps
`default_nettype none
`include "mcu8_cfg.svh"

module mcu8_instruction_execute
    import mcu8_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [15:0] pm_addr,
    input  wire logic [15:0] pm_rdata,
    output logic      [8:0]  dm_addr,
    output logic      [7:0]  dm_wdata,
    output logic             dm_we,
    input  wire logic [7:0]  dm_rdata,
    input  wire logic        timeout_status_bit,
    input  wire logic        power_down_status_bit,
    output logic             gie
);

    // ==========================================================
    // state
    // ==========================================================
    state_t      st_q;
    logic [1:0]  wait_q;
    logic        tbl_q;
    logic [15:0] pc_q;
    logic [7:0]  acc_q;
    logic        c_q;
    logic        dc_q;
    logic        z_q;
    logic [7:0]  r_q;
    logic [7:0]  yp_q;
    logic [7:0]  zp_q;
    logic [1:0]  page_q;
    logic        bank_q;
    logic        gie_q;
    logic        run_q;
    logic [7:0]  sh_acc_q;
    logic [2:0]  sh_fl_q;
    logic [15:0] stk_q [8];
    logic [2:0]  sp_q;
    logic        ack_q;
    logic [31:0] rdata_q;

    // ==========================================================
    // decode
    // ==========================================================
    logic [15:0] iw;
    op_t         op;
    logic        is_jmp, is_call, is_bit, is_bzmi, is_alu, bz;
    logic [7:0]  ea;
    logic        sysr, intl, go;
    logic [7:0]  mrd, flags_v, bmask;

    assign iw      = pm_rdata;
    assign op      = op_t'(iw[13:8]);
    assign is_jmp  = iw[15:14] == 2'b10;
    assign is_call = iw[15:14] == 2'b11;
    assign is_bit  = iw[15:14] == 2'b01;
    assign is_bzmi = iw[15:11] == 5'b00111;
    assign is_alu  = (iw[15:14] == 2'b00) && !is_bzmi;
    assign bz      = is_bzmi || (is_bit && iw[11]) || (is_alu &&
                     (op == op_bz_ld_m || op == op_bz_st_m ||
                      op == op_bz_trade || op == op_bz_add_m));
    // target index is only three bits wide, so nothing outside 0x80..0x87
    assign ea      = is_bzmi ? {`SR_BASE, iw[10:8]} : iw[7:0];
    assign sysr    = ea[7];
    assign intl    = ea[7:3] == `SR_BASE;
    assign bmask   = 8'h01 << iw[10:8];
    assign go      = run_q && (st_q == st_exec);
    assign flags_v = {timeout_status_bit, power_down_status_bit, 3'b000,
                      z_q, dc_q, c_q};

    // operand read: internal window or data memory
    always_comb begin
        if (!intl)                mrd = dm_rdata;
        else if (ea == `SR_R)     mrd = r_q;
        else if (ea == `SR_ZP)    mrd = zp_q;
        else if (ea == `SR_YP)    mrd = yp_q;
        else if (ea == `SR_PAGE)  mrd = {6'h00, page_q};
        else if (ea == `SR_FLAG)  mrd = flags_v;
        else if (ea == `SR_BANK)  mrd = {7'h00, bank_q};
        else                      mrd = `RST_BYTE;
    end

    // ==========================================================
    // execute
    // ==========================================================
    logic        a_we, m_we, c_we, dc_we, z_we, r_we, skip;
    logic        alu, inv, ci, to_m, no_st, push, pop, gie_set;
    logic        save, restore, tbl;
    logic [7:0]  a_d, m_d, r_d, src, opb, res;
    logic        c_n, dc_n, z_n;
    logic [1:0]  xtra;
    logic [15:0] pc_n, prod;
    logic [8:0]  sum;
    logic [4:0]  hsum;

    always_comb begin
        a_we = 1'b0; m_we = 1'b0; c_we = 1'b0; dc_we = 1'b0;
        z_we = 1'b0; r_we = 1'b0; skip = 1'b0; alu = 1'b0;
        inv = 1'b0; ci = 1'b0; to_m = 1'b0; no_st = 1'b0;
        push = 1'b0; pop = 1'b0; gie_set = 1'b0; save = 1'b0;
        restore = 1'b0; tbl = 1'b0;
        a_d = acc_q; m_d = mrd; r_d = r_q; res = acc_q;
        c_n = c_q; dc_n = dc_q; z_n = z_q;
        xtra = `XC_NONE;
        pc_n = pc_q + 16'h0001;
        prod = {8'h00, acc_q} * {8'h00, mrd};
        src = (is_alu && (op == op_ld_i || op == op_add_i || op == op_sub_i ||
               op == op_and_i || op == op_or_i || op == op_xor_i ||
               op == op_cmp_i)) ? iw[7:0] : mrd;
        if (is_jmp || is_call) begin
            pc_n = {page_q, iw[13:0]};
            xtra = `XC_TWO;
            push = is_call;
        end else if (is_bzmi) begin
            m_we = 1'b1;
            m_d  = iw[7:0];
        end else if (is_bit) begin
            case (iw[13:12])
                2'd0: begin m_we = 1'b1; m_d = mrd & ~bmask; end
                2'd1: begin m_we = 1'b1; m_d = mrd | bmask; end
                2'd2: skip = (mrd & bmask) == 8'h00;
                default: skip = (mrd & bmask) != 8'h00;
            endcase
        end else begin
            case (op)
                op_ld_m, op_bz_ld_m: begin
                    a_we = 1'b1; a_d = mrd; z_we = 1'b1; z_n = mrd == 8'h00;
                end
                op_st_m, op_bz_st_m: begin m_we = 1'b1; m_d = acc_q; end
                op_ld_i: begin a_we = 1'b1; a_d = iw[7:0]; end
                op_trade, op_bz_trade: begin
                    a_we = 1'b1; a_d = mrd; m_we = 1'b1; m_d = acc_q;
                end
                op_table_rd: begin tbl = 1'b1; xtra = `XC_TWO; end
                op_addc_a: begin alu = 1'b1; ci = c_q; end
                op_addc_m: begin alu = 1'b1; ci = c_q; to_m = 1'b1; end
                op_add_a, op_add_i: alu = 1'b1;
                op_add_m, op_bz_add_m: begin alu = 1'b1; to_m = 1'b1; end
                op_subb_a: begin alu = 1'b1; inv = 1'b1; ci = c_q; end
                op_subb_m: begin
                    alu = 1'b1; inv = 1'b1; ci = c_q; to_m = 1'b1;
                end
                op_sub_a, op_sub_i: begin alu = 1'b1; inv = 1'b1; ci = 1'b1; end
                op_sub_m: begin
                    alu = 1'b1; inv = 1'b1; ci = 1'b1; to_m = 1'b1;
                end
                op_cmp_i, op_cmp_m: begin
                    alu = 1'b1; inv = 1'b1; ci = 1'b1; no_st = 1'b1;
                end
                op_dec_adj: begin
                    a_we = 1'b1;
                    c_we = 1'b1;
                    c_n  = c_q || (acc_q > 8'h99);
                    a_d  = acc_q + {c_n ? 4'h6 : 4'h0,
                                    (dc_q || acc_q[3:0] > 4'h9) ? 4'h6 : 4'h0};
                end
                op_product: begin
                    a_we = 1'b1; a_d = prod[7:0];
                    r_we = 1'b1; r_d = prod[15:8];
                    z_we = 1'b1; z_n = prod[7:0] == 8'h00;
                    xtra = `XC_TWO;
                end
                op_and_a, op_and_i, op_and_m: res = acc_q & src;
                op_or_a, op_or_i, op_or_m:    res = acc_q | src;
                op_xor_a, op_xor_i, op_xor_m: res = acc_q ^ src;
                op_nib_a: begin a_we = 1'b1; a_d = {mrd[3:0], mrd[7:4]}; end
                op_nib_m: begin m_we = 1'b1; m_d = {mrd[3:0], mrd[7:4]}; end
                op_rotr_a, op_rotr_m: begin
                    res = {c_q, mrd[7:1]}; c_we = 1'b1; c_n = mrd[0];
                end
                op_rotl_a, op_rotl_m: begin
                    res = {mrd[6:0], c_q}; c_we = 1'b1; c_n = mrd[7];
                end
                op_clr_m: begin m_we = 1'b1; m_d = 8'h00; end
                op_inc_a, op_dec_a: begin
                    a_we = 1'b1;
                    a_d  = (op == op_inc_a) ? mrd + 8'h01 : mrd - 8'h01;
                    skip = a_d == 8'h00;
                end
                op_inc_m, op_dec_m: begin
                    m_we = 1'b1;
                    m_d  = (op == op_inc_m) ? mrd + 8'h01 : mrd - 8'h01;
                    skip = m_d == 8'h00;
                end
                op_ret, op_iret: begin
                    pop = 1'b1;
                    pc_n = stk_q[sp_q - 3'd1];
                    xtra = `XC_TWO;
                    gie_set = op == op_iret;
                end
                op_save: save = 1'b1;
                op_restore: restore = 1'b1;
                default: ;
            endcase
            // logic results
            if (op == op_and_a || op == op_and_i || op == op_or_a ||
                op == op_or_i || op == op_xor_a || op == op_xor_i) begin
                a_we = 1'b1; a_d = res; z_we = 1'b1; z_n = res == 8'h00;
            end
            if (op == op_and_m || op == op_or_m || op == op_xor_m) begin
                m_we = 1'b1; m_d = res; z_we = 1'b1; z_n = res == 8'h00;
            end
            if (op == op_rotr_a || op == op_rotl_a) begin a_we = 1'b1; a_d = res; end
            if (op == op_rotr_m || op == op_rotl_m) begin m_we = 1'b1; m_d = res; end
        end
        // shared adder: subtract is a + ~b + ci, so carry out means no borrow
        opb  = inv ? ~src : src;
        sum  = {1'b0, acc_q} + {1'b0, opb} + {8'h00, ci};
        hsum = {1'b0, acc_q[3:0]} + {1'b0, opb[3:0]} + {4'h0, ci};
        if (alu) begin
            c_we = 1'b1; c_n = sum[8];
            z_we = 1'b1; z_n = sum[7:0] == 8'h00;
            dc_we = !no_st; dc_n = hsum[4];
            if (no_st)     skip = sum[7:0] == 8'h00;
            else if (to_m) begin m_we = 1'b1; m_d = sum[7:0]; end
            else           begin a_we = 1'b1; a_d = sum[7:0]; end
        end
        if (skip) begin
            pc_n = pc_q + 16'h0002;
            xtra = xtra + 2'd1;
        end
        // plain stores and clear stay single cycle even into ram
        if (m_we && !sysr && !(is_alu && (op == op_st_m || op == op_bz_st_m ||
            op == op_clr_m))) xtra = xtra + 2'd1;
        if (!go) begin
            a_we = 1'b0; m_we = 1'b0; c_we = 1'b0; dc_we = 1'b0; z_we = 1'b0;
            r_we = 1'b0; push = 1'b0; pop = 1'b0; gie_set = 1'b0;
            save = 1'b0; restore = 1'b0; tbl = 1'b0;
        end
    end

    // memory port; internal window is never sent out
    assign dm_addr  = {bz ? 1'b0 : bank_q, ea};
    assign dm_wdata = m_d;
    assign dm_we    = m_we && !intl;
    // table read borrows the program port during its second cycle
    assign pm_addr  = (st_q == st_wait && tbl_q) ? {yp_q, zp_q} : pc_q;

    // ==========================================================
    // sequencing
    // ==========================================================
    // halting only takes effect at an instruction boundary
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= st_exec; wait_q <= `XC_NONE; tbl_q <= 1'b0; pc_q <= `RST_PC;
        end else if (go) begin
            pc_q  <= pc_n;
            tbl_q <= tbl;
            if (xtra != `XC_NONE) begin
                st_q <= st_wait; wait_q <= xtra;
            end
        end else if (st_q == st_wait) begin
            wait_q <= wait_q - 2'd1;
            if (wait_q == 2'd1) begin st_q <= st_exec; tbl_q <= 1'b0; end
        end
    end

    // return stack wraps silently after eight nested calls
    always_ff @(posedge mclk) begin
        if (rst) begin
            sp_q <= 3'd0;
        end else if (push) begin
            stk_q[sp_q] <= pc_q + 16'h0001;
            sp_q <= sp_q + 3'd1;
        end else if (pop) begin
            sp_q <= sp_q - 3'd1;
        end
    end

    // accumulator and R
    always_ff @(posedge mclk) begin
        if (rst) begin
            acc_q <= `RST_BYTE; r_q <= `RST_BYTE;
        end else if (st_q == st_wait && tbl_q) begin
            acc_q <= pm_rdata[7:0]; r_q <= pm_rdata[15:8];
        end else begin
            if (a_we)    acc_q <= a_d;
            if (restore) acc_q <= sh_acc_q;
            if (r_we)    r_q <= r_d;
            else if (m_we && ea == `SR_R) r_q <= m_d;
        end
    end

    // flags: an explicit flag result beats a store into the flag register
    always_ff @(posedge mclk) begin
        if (rst) begin
            c_q <= 1'b0; dc_q <= 1'b0; z_q <= 1'b0;
        end else begin
            if (m_we && ea == `SR_FLAG) begin
                c_q <= m_d[`FL_C]; dc_q <= m_d[`FL_DC]; z_q <= m_d[`FL_Z];
            end
            if (c_we)  c_q <= c_n;
            if (dc_we) dc_q <= dc_n;
            if (z_we)  z_q <= z_n;
            if (restore) begin
                c_q <= sh_fl_q[`FL_C]; dc_q <= sh_fl_q[`FL_DC]; z_q <= sh_fl_q[`FL_Z];
            end
        end
    end

    // shadow buffers hold no timeout or power-down bit at all
    always_ff @(posedge mclk) begin
        if (rst) begin
            sh_acc_q <= `RST_BYTE; sh_fl_q <= 3'b000;
        end else if (save) begin
            sh_acc_q <= acc_q; sh_fl_q <= {z_q, dc_q, c_q};
        end
    end

    // pointer, page and bank registers in the internal window
    always_ff @(posedge mclk) begin
        if (rst) begin
            yp_q <= `RST_BYTE; zp_q <= `RST_BYTE; page_q <= 2'b00; bank_q <= 1'b0;
        end else if (m_we) begin
            if (ea == `SR_YP)   yp_q <= m_d;
            if (ea == `SR_ZP)   zp_q <= m_d;
            if (ea == `SR_PAGE) page_q <= m_d[1:0];
            if (ea == `SR_BANK) bank_q <= m_d[0];
        end
    end

    // ==========================================================
    // register bus slave
    // ==========================================================
    logic req, take;
    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_q;
    assign take            = avs_write && ack_q;
    assign avs_readdata    = rdata_q;
    assign gie             = gie_q;

    // every access answers on its second edge
    always_ff @(posedge mclk) begin
        if (rst) ack_q <= 1'b0;
        else     ack_q <= req && !ack_q;
    end

    // read data captured on the first edge, stands through the second
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            if (avs_address == `CSR_CTRL)
                rdata_q <= {31'h0000_0000, run_q};
            else if (avs_address == `CSR_STAT)
                rdata_q <= {24'h00_0000, sp_q, tbl_q, wait_q, gie_q, st_q == st_wait};
            else if (avs_address == `CSR_CORE)
                rdata_q <= {8'h00, r_q, flags_v, acc_q};
            else if (avs_address == `CSR_PTR)
                rdata_q <= {pc_q, yp_q, zp_q};
            else
                rdata_q <= 32'h0000_0000;
        end
    end

    // run control; interrupt return sets enable and wins over a clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            run_q <= 1'b0; gie_q <= 1'b0;
        end else begin
            if (take && avs_address == `CSR_CTRL) begin
                run_q <= avs_writedata[`CTRL_RUN];
                if (avs_writedata[`CTRL_GIE_CLR]) gie_q <= 1'b0;
            end
            if (gie_set) gie_q <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// ### tb/mcu8_exec_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ================================================================
// execute checker
module mcu8_exec_chk
    import mcu8_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [15:0] pm_addr,
    input wire logic [15:0] pm_rdata,
    input wire logic [8:0]  dm_addr,
    input wire logic [7:0]  dm_wdata,
    input wire logic        dm_we,
    input wire logic [7:0]  dm_rdata,
    input wire logic        timeout_status_bit,
    input wire logic        power_down_status_bit,
    input wire logic        gie
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [7:0] op;
    // opcode byte of the word in its execute clock
    assign op = pm_rdata[15:8];
    // a store made by opcode x, and the same store landing in ram
    sequence st_by(x);
        dm_we && op == {2'b00, x};
    endsequence
    sequence ram_st(x);
        st_by(x) ##0 !dm_addr[7];
    endsequence
    bit_write_a: assert property (dm_we && pm_rdata[15:13] == 3'b010 |->
        dm_wdata == (pm_rdata[12] ? dm_rdata | (8'h01 << pm_rdata[10:8])
            : dm_rdata & ~(8'h01 << pm_rdata[10:8]))) else $error("bit write spilled");
    bank_zero_a: assert property (((dm_we && pm_rdata[15:13] == 3'b010 && pm_rdata[11])
        or st_by(op_bz_add_m)) |-> dm_addr == {1'b0, pm_rdata[7:0]})
        else $error("bank zero form missed bank zero");
    nib_swap_a: assert property (st_by(op_nib_m) |->
        dm_wdata == {dm_rdata[3:0], dm_rdata[7:4]}) else $error("nibbles not swapped");
    rotate_mem_a: assert property (dm_we |->
        (op != {2'b00, op_rotr_m} || dm_wdata[6:0] == dm_rdata[7:1]) &&
        (op != {2'b00, op_rotl_m} || dm_wdata[7:1] == dm_rdata[6:0])) else $error("bad rotate");
    step_value_a: assert property (dm_we |->
        (op != {2'b00, op_inc_m} || dm_wdata == dm_rdata + 8'h01) &&
        (op != {2'b00, op_dec_m} || dm_wdata == dm_rdata - 8'h01)) else $error("bad step");
    skip_time_a: assert property (ram_st(op_inc_m) ##0 dm_wdata == 8'h00 |->
        ##3 pm_addr == $past(pm_addr, 3) + 16'd2) else $error("skip took wrong time");
    step_time_a: assert property (ram_st(op_dec_m) ##0 dm_wdata != 8'h00 |->
        ##2 pm_addr == $past(pm_addr, 2) + 16'd1) else $error("ram store wrong time");
    no_store_a: assert property (dm_we |-> op != {2'b00, op_cmp_i} &&
        op != {2'b00, op_cmp_m} && pm_rdata[15:13] != 3'b011) else $error("test stored");
    gie_rise_a: assert property ($rose(gie) |-> $past(op) == {2'b00, op_iret} ||
        $past(op, 2) == {2'b00, op_iret}) else $error("enable rose without return");
    gie_fall_a: assert property ($fell(gie) |-> $past(avs_write && !avs_waitrequest &&
        avs_address == 4'h0 && avs_writedata[1])) else $error("enable dropped alone");
endmodule
bind mcu8_instruction_execute mcu8_exec_chk chk_i (
    .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rdata(dm_rdata),
    .timeout_status_bit(timeout_status_bit),
    .power_down_status_bit(power_down_status_bit), .gie(gie));
`default_nettype wire

// ### tb/mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// ================================================================
// program and data memory
module mem_model (
    input  wire logic        mclk,
    input  wire logic [15:0] pm_addr,
    output logic      [15:0] pm_rdata,
    input  wire logic [8:0]  dm_addr,
    input  wire logic [7:0]  dm_wdata,
    input  wire logic        dm_we,
    output logic      [7:0]  dm_rdata
);
    logic [15:0] rom [256];
    logic [7:0]  ram [512];
    // reads are asynchronous; rom wraps every 256 words, runs stay short
    assign pm_rdata = rom[pm_addr[7:0]];
    assign dm_rdata = ram[dm_addr];
    // one byte stored per strobe
    always @(posedge mclk) begin
        if (dm_we) begin
            ram[dm_addr] <= dm_wdata;
        end
    end
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ================================================================
// bench for the execute core
module tb
    import mcu8_pkg::*;
();
    logic        mclk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic        tmo = 1'b1, pdn = 1'b0, avs_waitrequest, dm_we, gie;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, mk;
    logic [15:0] pm_addr, pm_rdata, p, pg [20];
    logic [8:0]  dm_addr, s;
    logic [7:0]  dm_wdata, dm_rdata, a, b;
    logic [31:0] q_exp[$], q_msk[$];
    int          n_fail = 0, total_checks = 0;
    mcu8_instruction_execute dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pm_addr(pm_addr),
        .pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we),
        .dm_rdata(dm_rdata), .timeout_status_bit(tmo), .power_down_status_bit(pdn), .gie(gie));
    mem_model mem (.mclk(mclk), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
        .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rdata(dm_rdata));
    always #5 mclk = ~mclk;
    function automatic logic [15:0] w(op_t o, logic [7:0] v);
        return {2'b00, o, v};
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(logic wr, logic [3:0] ad, logic [31:0] d);
        avs_address <= ad;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(logic [3:0] ad, logic [31:0] e, logic [31:0] m);
        q_exp.push_back(e);
        q_msk.push_back(m);
        bus(1'b0, ad, 32'h0);
    endtask
    // restart the core from pc 0, let it run n clocks, then halt it
    task automatic run(int n);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        bus(1'b1, 4'h0, 32'h1);
        repeat (n) @(posedge mclk);
        bus(1'b1, 4'h0, 32'h0);
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // read data taken at the completing edge, against the oldest note
    always @(posedge mclk) begin
        if (avs_read && avs_waitrequest === 1'b0 && q_exp.size() > 0) begin
            mk = q_msk.pop_front();
            chk(avs_readdata & mk, q_exp.pop_front() & mk);
        end
    end
    // cut a hang short well past the expected few hundred clocks
    initial begin
        #200000;
        n_fail++;
        wrap_up;
    end
    initial begin
        void'($urandom(32'h3841));
        foreach (mem.rom[i]) mem.rom[i] = 16'h0000;
        foreach (mem.ram[i]) mem.ram[i] = 8'h00;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(4'h1, 32'h0, 32'hffffffff);
        for (int i = 0; i < 4; i++) begin
            a = 8'($urandom);
            b = 8'($urandom);
            mem.rom[0] = w(op_ld_i, a);
            mem.rom[1] = w(op_add_i, b);
            s = {1'b0, a} + {1'b0, b};
            run(6);
            rd(4'h8, {23'h0, s}, 32'h000001ff);
            mem.rom[1] = w(op_sub_i, b);
            s = {1'b0, a} - {1'b0, b};
            run(6);
            rd(4'h8, {23'h0, ~s[8], s[7:0]}, 32'h000001ff);
            mem.ram[8'h20] = b;
            mem.rom[1] = w(op_product, 8'h20);
            p = a * b;
            run(8);
            rd(4'h8, {8'h0, p[15:8], 5'h0, p[7:0] == 8'h0, 2'h0, p[7:0]}, 32'h00ff04ff);
        end
        mem.rom[0] = w(op_ld_i, 8'h38);
        mem.rom[1] = w(op_add_i, 8'h49);
        mem.rom[2] = w(op_dec_adj, 8'h00);
        run(6);
        rd(4'h8, 32'h87, 32'h000000ff);
        $display("arithmetic done");
        pg = '{w(op_inc_m, 8'h10), w(op_inc_m, 8'h30), w(op_nib_m, 8'h11),
            w(op_rotr_m, 8'h12), w(op_rotl_m, 8'h13), 16'h5c14, 16'h4f15, 16'h7015,
            w(op_inc_m, 8'h31), w(op_dec_m, 8'h14), w(op_ld_i, 8'h40),
            w(op_bz_add_m, 8'h16), w(op_cmp_i, 8'h40), w(op_inc_m, 8'h32), 16'h8010,
            w(op_inc_m, 8'h33), 16'h3c00, 16'h3b20, w(op_table_rd, 8'h00), 16'h3f01};
        foreach (pg[i]) mem.rom[i] = pg[i];
        mem.rom[8'h20] = 16'h5a3e;
        mem.ram[8'h10] = 8'hff;
        mem.ram[8'h11] = 8'h3c;
        mem.ram[8'h12] = 8'hc3;
        mem.ram[8'h13] = 8'h81;
        mem.ram[8'h14] = 8'h05;
        mem.ram[8'h15] = 8'hff;
        mem.ram[8'h16] = 8'h02;
        run(40);
        rd(4'h8, 32'h005a853e, 32'h00ffc5ff);
        rd(4'hc, 32'h00000020, 32'h0000ffff);
        p = 16'h0000;
        foreach (pg[i]) if (i < 7) chk(mem.ram[8'h10 + i], {8'h00, 8'hc3, 8'h61, 8'h03,
            8'h14, 8'h7f, 8'h42} >> (8 * (6 - i)) & 8'hff);
        for (int i = 0; i < 4; i++) chk(mem.ram[8'h30 + i], 32'h0);
        $display("memory done");
        foreach (mem.rom[i]) mem.rom[i] = 16'h0000;
        pg[0:7] = '{16'hc004, w(op_add_i, 8'h01), 16'hc006, 16'h8003, w(op_ld_i, 8'h10),
            w(op_iret, 8'h00), w(op_add_i, 8'h02), w(op_ret, 8'h00)};
        foreach (pg[i]) mem.rom[i] = (i < 8) ? pg[i] : 16'h0000;
        run(30);
        rd(4'h8, 32'h13, 32'h000000ff);
        rd(4'hc, 32'h00030000, 32'hffff0000);
        chk(gie, 32'h1);
        bus(1'b1, 4'h0, 32'h2);
        chk(gie, 32'h0);
        tmo <= 1'b0;
        pdn <= 1'b1;
        pg[0:3] = '{w(op_ld_i, 8'h5a), w(op_save, 8'h0), w(op_ld_i, 8'h01), w(op_restore, 8'h0)};
        foreach (pg[i]) mem.rom[i] = (i < 4) ? pg[i] : 16'h0000;
        run(10);
        rd(4'h8, 32'h0000405a, 32'h0000c0ff);
        $display("flow done");
        wrap_up;
    end
endmodule
`default_nettype wire
